// >>> bmfr_pkg.sv
// Package for the bus-management initial-value and fairness register group.
// Assumes a 32-bit register port and a single 250 MHz controller clock.
// Overview of operation
// - Bandwidth field, 13 bits, resets to 1333h; bus reset leaves it alone.
// - Bandwidth field copied into bandwidth CSR on global, fundamental, power, bus reset.
// - Bandwidth register bits 31-13 read as zero.
// - Channels-high field resets to all ones; bus reset keeps it; software read/write.
// - Channels-high field copied into its CSR on any load event.
// - Channels-low field resets to all ones; bus reset keeps it; software read/write.
// - Channels-low field copied into its CSR on any load event.
// - Priority arbitration requests per fairness interval limited to programmed field.
// - Priority request limit resets to zero, so no priority requests allowed.
// - Fairness register bits 31-8 read as zero.
package bmfr_pkg;
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 32;
  localparam int          BW_W           = 13;
  localparam int          PRI_W          = 8;
  localparam int          NUM_CSR        = 3;
  localparam logic [7:0]  OFF_INIT_BW    = 8'hb0;
  localparam logic [7:0]  OFF_INIT_CH_HI = 8'hb4;
  localparam logic [7:0]  OFF_INIT_CH_LO = 8'hb8;
  localparam logic [7:0]  OFF_FAIRNESS   = 8'hdc;
  localparam logic [12:0] RST_INIT_BW    = 13'h1333;
  localparam logic [31:0] RST_INIT_CH    = 32'hffffffff;
  localparam logic [7:0]  RST_PRI_REQ    = 8'h00;
  localparam logic [31:0] RST_ZERO       = 32'h00000000;
  localparam int          CSR_BW         = 0;
  localparam int          CSR_CH_HI      = 1;
  localparam int          CSR_CH_LO      = 2;

  // Register bus request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bmfr_req_t;

  // Sources that reload the bus-management CSRs
  typedef struct packed {
    logic global_rst;
    logic fund_rst;
    logic power_rst;
    logic bus_rst;
  } bmfr_load_t;

  typedef enum logic [1:0] {ST_IDLE, ST_GRANT, ST_WAIT} bmfr_arb_st_t;
endpackage

// >>> bmfr_csr_load.sv
// Bus-management CSR images reloaded from the initial values.
// Assumes load events are one cycle or longer, synchronous to sys_clk_in.
`timescale 1ns/1ps
module bmfr_csr_load
  import bmfr_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk_in,
  input  wire logic              resetn_in,
  // Load and sources
  input  wire logic              load_in,
  input  wire logic [31:0]       init_in [NUM_CSR],
  // CSR images
  output logic      [31:0]       csr_out [NUM_CSR]
);
  // One reload flop per CSR
  genvar g;
  generate
    for (g = 0; g < NUM_CSR; g++) begin : g_csr
      logic [31:0] csr_q;
      always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          csr_q <= (g == CSR_BW) ? {{(DATA_W-BW_W){1'b0}}, RST_INIT_BW} : RST_INIT_CH;
        end else if (load_in) begin
          csr_q <= init_in[g]; // Whole word replaced
        end
      end
      assign csr_out[g] = csr_q;
      p_reload: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        load_in |=> csr_q == $past(init_in[g]))
        else $error("CSR not reloaded");
    end
  endgenerate
endmodule

// >>> bmfr_fair.sv
// Priority request limiter for one fairness interval.
// Assumes arbitration logic pulses req and interval start for one cycle.
`timescale 1ns/1ps
module bmfr_fair
  import bmfr_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk_in,
  input  wire logic              resetn_in,
  // Arbitration side
  input  wire logic [PRI_W-1:0]  limit_in,
  input  wire logic              interval_start_in,
  input  wire logic              pri_req_in,
  output logic                   pri_grant_out,
  output logic [PRI_W-1:0]       used_out
);
  logic [PRI_W-1:0] used_q;
  logic [PRI_W-1:0] used_d;
  logic             grant_q;
  wire              allow = (used_q < limit_in); // Zero limit allows none
  wire              take  = pri_req_in && allow;

  // Count grants; a new interval restarts the budget
  assign used_d = interval_start_in ? '0 : (take ? used_q + PRI_W'(1) : used_q);
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      used_q  <= '0;
      grant_q <= 1'b0;
    end else begin
      used_q  <= used_d;
      grant_q <= take && !interval_start_in;
    end
  end
  assign pri_grant_out = grant_q;
  assign used_out      = used_q;

  p_limit: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    used_q <= limit_in || $changed(limit_in) || $past(interval_start_in))
    else $error("Priority grants exceed limit");
  p_zero: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    ($past(limit_in) == '0 && $stable(limit_in)) |-> !pri_grant_out)
    else $error("Grant given with zero limit");
endmodule

// >>> bmfr_regs.sv
// Initial bandwidth/channel registers, fairness control and CSR reload.
// Assumes a one-cycle strobe register port; read data appear next cycle.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
module bmfr_regs
  import bmfr_pkg::*;
(
  // Clock and reset
  input  wire logic                  sys_clk_in,
  input  wire logic                  resetn_in,
  input  wire logic                  soft_reset_in,
  // Register port
  input  wire bmfr_pkg::bmfr_req_t   req_in,
  output logic [31:0]                rdata_out,
  // Load sources
  input  wire bmfr_pkg::bmfr_load_t  load_src_in,
  // Bus-management CSR images
  output logic [31:0]                bw_avail_csr_out,
  output logic [31:0]                ch_avail_hi_csr_out,
  output logic [31:0]                ch_avail_lo_csr_out,
  // Arbitration
  input  wire logic                  interval_start_in,
  input  wire logic                  pri_req_in,
  output logic                       pri_grant_out
);
  // Software-held initial values
  logic [BW_W-1:0]   initial_bandwidth_value_q;
  logic [31:0]       initial_channels_high_value_q;
  logic [31:0]       initial_channels_low_value_q;
  logic [PRI_W-1:0]  pri_req_limit_q;
  logic [31:0]       rdata_q;
  logic [31:0]       rdata_d;
  logic [31:0]       init_vec [NUM_CSR];
  logic [31:0]       csr_vec  [NUM_CSR];
  logic [PRI_W-1:0]  used;
  logic              grant;

  // Address decode
  wire hit_bw   = req_in.addr == OFF_INIT_BW;
  wire hit_hi   = req_in.addr == OFF_INIT_CH_HI;
  wire hit_lo   = req_in.addr == OFF_INIT_CH_LO;
  wire hit_fair = req_in.addr == OFF_FAIRNESS;
  wire wr_bw    = req_in.wr && hit_bw;
  wire wr_hi    = req_in.wr && hit_hi;
  wire wr_lo    = req_in.wr && hit_lo;
  wire wr_fair  = req_in.wr && hit_fair;

  // Any of the four reset kinds reloads the CSRs
  wire load_evt = load_src_in.global_rst || load_src_in.fund_rst ||
                  load_src_in.power_rst  || load_src_in.bus_rst;

  // Initial values; soft reset restores defaults, bus reset does not touch them
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      initial_bandwidth_value_q     <= RST_INIT_BW;
      initial_channels_high_value_q <= RST_INIT_CH;
      initial_channels_low_value_q  <= RST_INIT_CH;
      pri_req_limit_q               <= RST_PRI_REQ;
    end else if (soft_reset_in) begin
      initial_bandwidth_value_q     <= RST_INIT_BW;
      initial_channels_high_value_q <= RST_INIT_CH;
      initial_channels_low_value_q  <= RST_INIT_CH;
      pri_req_limit_q               <= RST_PRI_REQ;
    end else begin
      if (wr_bw)   initial_bandwidth_value_q     <= req_in.wdata[BW_W-1:0];
      if (wr_hi)   initial_channels_high_value_q <= req_in.wdata;
      if (wr_lo)   initial_channels_low_value_q  <= req_in.wdata;
      if (wr_fair) pri_req_limit_q               <= req_in.wdata[PRI_W-1:0];
    end
  end

  // Read mux; reserved upper bits are zero, unmapped reads zero
  always_comb begin
    rdata_d = RST_ZERO;
    if (req_in.rd) begin
      if (hit_bw)   rdata_d = {{(DATA_W-BW_W){1'b0}}, initial_bandwidth_value_q};
      if (hit_hi)   rdata_d = initial_channels_high_value_q;
      if (hit_lo)   rdata_d = initial_channels_low_value_q;
      if (hit_fair) rdata_d = {{(DATA_W-PRI_W){1'b0}}, pri_req_limit_q};
    end
  end
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) rdata_q <= RST_ZERO;
    else            rdata_q <= rdata_d;
  end
  assign rdata_out = rdata_q;

  // Reload path uses the value held now, including earlier writes
  assign init_vec[CSR_BW]    = {{(DATA_W-BW_W){1'b0}}, initial_bandwidth_value_q};
  assign init_vec[CSR_CH_HI] = initial_channels_high_value_q;
  assign init_vec[CSR_CH_LO] = initial_channels_low_value_q;

  bmfr_csr_load u_load (
    .sys_clk_in (sys_clk_in),
    .resetn_in  (resetn_in),
    .load_in    (load_evt),
    .init_in    (init_vec),
    .csr_out    (csr_vec)
  );
  assign bw_avail_csr_out    = csr_vec[CSR_BW];
  assign ch_avail_hi_csr_out = csr_vec[CSR_CH_HI];
  assign ch_avail_lo_csr_out = csr_vec[CSR_CH_LO];

  bmfr_fair u_fair (
    .sys_clk_in        (sys_clk_in),
    .resetn_in         (resetn_in),
    .limit_in          (pri_req_limit_q),
    .interval_start_in (interval_start_in),
    .pri_req_in        (pri_req_in),
    .pri_grant_out     (grant),
    .used_out          (used)
  );
  assign pri_grant_out = grant;

  p_bw_keep: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (load_src_in.bus_rst && !soft_reset_in && !wr_bw) |=> $stable(initial_bandwidth_value_q))
    else $error("Bus reset changed bandwidth value");
  p_bw_soft: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    soft_reset_in |=> initial_bandwidth_value_q == RST_INIT_BW)
    else $error("Soft reset missed bandwidth default");
  p_bw_load: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    load_evt |=> bw_avail_csr_out == {19'h0, $past(initial_bandwidth_value_q)})
    else $error("Bandwidth CSR not loaded");
  p_bw_rsvd: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (req_in.rd && hit_bw) |=> rdata_out[31:BW_W] == '0)
    else $error("Bandwidth reserved bits nonzero");
  p_hi_rw: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (wr_hi && !soft_reset_in) ##1 (req_in.rd && hit_hi && !wr_hi) |=>
      rdata_out == $past(req_in.wdata, 2))
    else $error("Channels high readback wrong");
  p_hi_load: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    load_evt |=> ch_avail_hi_csr_out == $past(initial_channels_high_value_q))
    else $error("Channels high CSR not loaded");
  p_lo_soft: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    soft_reset_in |=> initial_channels_low_value_q == RST_INIT_CH)
    else $error("Soft reset missed channels low default");
  p_lo_load: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    load_evt |=> ch_avail_lo_csr_out == $past(initial_channels_low_value_q))
    else $error("Channels low CSR not loaded");
  p_fair_rsvd: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (req_in.rd && hit_fair) |=> rdata_out[31:PRI_W] == '0)
    else $error("Fairness reserved bits nonzero");
  p_fair_soft: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    soft_reset_in |=> pri_req_limit_q == RST_PRI_REQ)
    else $error("Priority limit not cleared");
endmodule

// >>> bmfr_tb.sv
// Self-checking bench for the initial-value and fairness register group.
// Assumes bmfr_pkg and bmfr_regs are compiled first; assertions live in the design.
`timescale 1ns/1ps
module tb;
  import bmfr_pkg::*;
  // Stimulus and observed outputs
  logic        sys_clk_in     = 1'b0;
  logic        resetn_in      = 1'b0;
  logic        soft_reset_in  = 1'b0;
  bmfr_req_t   req            = '0;
  bmfr_load_t  ld             = '0;
  logic        interval_start = 1'b0;
  logic        pri_req        = 1'b0;
  logic [31:0] rdata, bw_csr, hi_csr, lo_csr;
  logic        grant;
  int          failures = 0;
  int          n_checks = 0;
  int          seed     = 86;
  // Behavioural model of the register contents and CSR images
  logic [31:0] m_init [NUM_CSR];
  logic [31:0] m_csr  [NUM_CSR];
  logic [31:0] m_fair;
  logic [7:0]  addrs  [5] = '{OFF_INIT_BW, OFF_INIT_CH_HI, OFF_INIT_CH_LO, OFF_FAIRNESS, 8'hc0};

  always #2 sys_clk_in = ~sys_clk_in;

  bmfr_regs u_bmfr_regs (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .soft_reset_in(soft_reset_in),
    .req_in(req), .rdata_out(rdata), .load_src_in(ld), .bw_avail_csr_out(bw_csr),
    .ch_avail_hi_csr_out(hi_csr), .ch_avail_lo_csr_out(lo_csr), .interval_start_in(interval_start),
    .pri_req_in(pri_req), .pri_grant_out(grant));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Expected read value; reserved bits always zero
  function automatic logic [31:0] model_rd(logic [7:0] a);
    case (a)
      OFF_INIT_BW:    return m_init[CSR_BW] & 32'h00001fff;
      OFF_INIT_CH_HI: return m_init[CSR_CH_HI];
      OFF_INIT_CH_LO: return m_init[CSR_CH_LO];
      OFF_FAIRNESS:   return m_fair & 32'h000000ff;
      default:        return 32'h00000000;
    endcase
  endfunction

  // One-cycle write, entered just after a rising edge
  task automatic wr(logic [7:0] a, logic [31:0] d);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge sys_clk_in);
    req.wr <= 1'b0;
    if (a == OFF_INIT_BW) m_init[CSR_BW] = d & 32'h00001fff;
    if (a == OFF_INIT_CH_HI) m_init[CSR_CH_HI] = d;
    if (a == OFF_INIT_CH_LO) m_init[CSR_CH_LO] = d;
    if (a == OFF_FAIRNESS) m_fair = d & 32'h000000ff;
  endtask

  // Read; data valid only in the following cycle
  task automatic rd(logic [7:0] a);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge sys_clk_in);
    req.rd <= 1'b0;
    #1 check("rdata", rdata, model_rd(a));
    @(posedge sys_clk_in);
  endtask

  task automatic check_csrs();
    check("bw_csr", bw_csr, m_csr[CSR_BW]);
    check("hi_csr", hi_csr, m_csr[CSR_CH_HI]);
    check("lo_csr", lo_csr, m_csr[CSR_CH_LO]);
  endtask

  // Pulse one load source; images take the current initial values
  task automatic load(int src);
    ld <= bmfr_load_t'(4'b0001 << src);
    @(posedge sys_clk_in);
    ld <= '0;
    m_csr = m_init;
    #1 check_csrs();
    @(posedge sys_clk_in);
  endtask

  // Program a limit, open an interval and count grants against it
  task automatic fair(logic [7:0] lim, int nreq);
    int used;
    wr(OFF_FAIRNESS, {$random(seed)} & 32'hffffff00 | {24'h0, lim});
    interval_start <= 1'b1;
    @(posedge sys_clk_in);
    interval_start <= 1'b0;
    used = 0;
    for (int i = 0; i < nreq; i++) begin
      pri_req <= 1'b1;
      @(posedge sys_clk_in);
      #1 check("grant", {31'h0, grant}, {31'h0, used < lim});
      if (used < lim) used++;
    end
    // Request in the same cycle as a new interval is refused
    interval_start <= 1'b1;
    @(posedge sys_clk_in);
    interval_start <= 1'b0;
    #1 check("grant_at_start", {31'h0, grant}, 32'h0);
    @(posedge sys_clk_in);
    pri_req <= 1'b0;
    #1 check("grant_new_interval", {31'h0, grant}, {31'h0, lim != 8'h00});
    @(posedge sys_clk_in);
  endtask

  // Hang guard
  initial begin
    #200000;
    failures++;
    complete_run();
  end

  initial begin
    m_init = '{32'h00001333, 32'hffffffff, 32'hffffffff};
    m_csr  = m_init;
    m_fair = 32'h0;
    repeat (20) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    @(posedge sys_clk_in);
    #1 check_csrs();
    @(posedge sys_clk_in);
    for (int i = 0; i < 5; i++) rd(addrs[i]);
    $display("test reset_values done");
    // Random traffic, unmapped address included
    repeat (4) for (int i = 0; i < 5; i++) begin
      wr(addrs[i], $random(seed));
      rd(addrs[i]);
    end
    $display("test random_access done");
    // Every load source; init registers survive the load
    for (int s = 0; s < 4; s++) begin
      // Write then read back, so no write strobe is lowered and raised in one step
      for (int i = 0; i < 3; i++) begin
        wr(addrs[i], $random(seed));
        rd(addrs[i]);
      end
      load(s);
      for (int i = 0; i < 3; i++) rd(addrs[i]);
    end
    $display("test load_events done");
    // Soft reset restores defaults, leaves images alone
    soft_reset_in <= 1'b1;
    @(posedge sys_clk_in);
    soft_reset_in <= 1'b0;
    m_init = '{32'h00001333, 32'hffffffff, 32'hffffffff};
    m_fair = 32'h0;
    #1 check_csrs();
    @(posedge sys_clk_in);
    for (int i = 0; i < 4; i++) rd(addrs[i]);
    $display("test soft_reset done");
    fair(8'h00, 3);
    fair(8'h01, 3);
    fair(8'h03, 6);
    $display("test fairness done");
    complete_run();
  end
endmodule
